/* lct_pkg.sv */
// shared constants and types for the linear ccd timing controller
`default_nettype none
package lct_pkg;
	// clock and derived cycle counts
	localparam int CLK_NS          = 4;
	localparam int TG_RISE_DLY_NS  = 10;
	localparam int TG_TO_PG_NS     = 50;
	localparam int PG_WIDTH_NS     = 400;
	localparam int PG_TO_TG_NS     = 20;
	localparam int PG_TO_AB_NS     = 5;
	localparam int AB_WIDTH_NS     = 750;
	localparam int SHIFT_PERIOD_NS = 25;
	localparam int RG_HIGH_NS      = 5;
	// least times round up, the drain pulse rounds down
	localparam int TG_RISE_CYC = (TG_RISE_DLY_NS + CLK_NS - 1) / CLK_NS;
	localparam int TG_PG_CYC   = (TG_TO_PG_NS + CLK_NS - 1) / CLK_NS;
	localparam int PG_CYC      = (PG_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int PG_TG_CYC   = (PG_TO_TG_NS + CLK_NS - 1) / CLK_NS;
	localparam int PG_AB_CYC   = (PG_TO_AB_NS + CLK_NS - 1) / CLK_NS;
	localparam int AB_CYC      = AB_WIDTH_NS / CLK_NS;
	localparam int HALF_CYC    = (SHIFT_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	localparam int RG_CYC      = (RG_HIGH_NS + CLK_NS - 1) / CLK_NS;
	// line layout
	localparam int ACTIVE_PIX  = 1024;
	localparam int TRANS_PIX   = 2;
	localparam int LEAKY_PIX   = 2;
	localparam int IDX_W       = 12;
	localparam int VID_W       = 12;
	localparam int FIFO_DEPTH  = 16;

	typedef enum logic [1:0] {
		PIX_DARK   = 2'h0,
		PIX_LEAKY  = 2'h1,
		PIX_TRANS  = 2'h2,
		PIX_ACTIVE = 2'h3
	} lct_kind_t;

	typedef struct packed {
		lct_kind_t          kind;
		logic [IDX_W-1:0]   idx;
		logic [VID_W-1:0]   video;
	} lct_pix_t;

	typedef struct packed {
		logic tg;
		logic pg;
		logic ab;
		logic h1;
		logic h2;
		logic rg;
	} lct_pins_t;
endpackage
`default_nettype wire

/* lct_ctrl.sv */
// pixel fifo and gate/shift clock sequencer for a two-phase linear ccd
//
// Notes on behaviour
// - transfer gate stays low whenever charge integrates or pixels shift.
// - before a transfer, shift clocks stop with phase one high, two low.
// - transfer gate rises only after shift clocks end, at least 10 ns.
// - photo gate rises after transfer gate is high, held 400 ns.
// - photo gate falls first; transfer gate falls 20 ns later.
// - antiblooming pulse lasts about 750 ns to reset the photodiodes.
// - after transfer, the two shift phases alternate, at most 40 MHz.
// - shift phases stay complementary; halves are equal unless a full buffer stalls phase one high.
// - phase edges switch in the same clock edge, crossing mid level.
// - the two dark pixels next to transition pixels are tagged unusable.
// - per-line active count matches the fitted array: 512, 1024 or 2048.
// - reset gate is low before every falling edge of phase one.
// - antiblooming stays low outside its pulse, so photodiodes collect.
`default_nettype none

module lct_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// refuse depths the wrapping pointers cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
		$error("fifo depth must be a power of two");
	end

	typedef struct packed {
		logic [AW-1:0]    wr;
		logic [AW-1:0]    rd;
		logic [AW:0]      cnt;
		logic             ov;
		logic [WIDTH-1:0] od;
	} lct_fifo_st_t;

	lct_fifo_st_t     s_r;
	lct_fifo_st_t     s_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             to_mem;
	logic             from_mem;

	// storage plus a registered output word
	always_comb begin
		s_nxt    = s_r;
		in_ready = (s_r.cnt != (AW+1)'(DEPTH));
		push     = in_valid && in_ready;
		to_mem   = push;
		from_mem = 1'b0;
		if (!s_r.ov || out_ready) begin
			if (s_r.cnt != '0) begin
				from_mem = 1'b1;
				s_nxt.od = mem[s_r.rd];
				s_nxt.ov = 1'b1;
			end else if (push) begin
				to_mem   = 1'b0;
				s_nxt.od = in_data;
				s_nxt.ov = 1'b1;
			end else begin
				s_nxt.ov = 1'b0;
			end
		end
		if (to_mem)
			s_nxt.wr = s_r.wr + 1'b1;
		if (from_mem)
			s_nxt.rd = s_r.rd + 1'b1;
		s_nxt.cnt = s_r.cnt + (AW+1)'(to_mem) - (AW+1)'(from_mem);
		out_valid = s_r.ov;
		out_data  = s_r.od;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// storage array write port
	always_ff @(posedge clk) begin
		if (to_mem)
			mem[s_r.wr] <= in_data;
	end
endmodule

module lct_ctrl #(
	parameter int ACTIVE = lct_pkg::ACTIVE_PIX,
	parameter int DARK   = 8,
	parameter int TAIL   = 0
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        run,
	input  wire logic [lct_pkg::VID_W-1:0]   video_in,
	output var  logic                        transfer_gate_phase,
	output var  logic                        photo_gate_phase,
	output var  logic                        antiblooming_gate_phase,
	output var  logic                        shift_phase_one,
	output var  logic                        shift_phase_two,
	output var  logic                        output_reset_gate_phase,
	output var  logic                        pix_valid,
	input  wire logic                        pix_ready,
	output var  lct_pkg::lct_pix_t           pix_data
);
	localparam int LINE = DARK + 2 * lct_pkg::TRANS_PIX + ACTIVE + TAIL;
	// refuse line layouts the pixel counter cannot serve
	if (ACTIVE != 512 && ACTIVE != 1024 && ACTIVE != 2048) begin : g_act_chk
		$error("active pixel count must be 512, 1024 or 2048");
	end
	if (DARK < lct_pkg::LEAKY_PIX || TAIL < 0 || LINE >= (1 << lct_pkg::IDX_W)) begin : g_line_chk
		$error("line layout does not fit");
	end

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_TGDLY = 3'b001,
		ST_TGHI  = 3'b010,
		ST_PGHI  = 3'b011,
		ST_TGEND = 3'b100,
		ST_PIXA  = 3'b101,
		ST_PIXB  = 3'b110
	} lct_state_t;

	typedef struct packed {
		lct_state_t                st;
		logic [7:0]                cnt;
		logic [7:0]                ab_cnt;
		logic [lct_pkg::IDX_W-1:0] pix;
		lct_pkg::lct_pins_t        p;
		logic [lct_pkg::VID_W-1:0] sync1;
		logic [lct_pkg::VID_W-1:0] sync2;
		logic                      push;
		lct_pkg::lct_pix_t         word;
	} lct_ctrl_st_t;

	localparam lct_ctrl_st_t RST_ST = '{st: ST_IDLE, p: '{h1: 1'b1, default: 1'b0}, default: '0};

	lct_ctrl_st_t s_r;
	lct_ctrl_st_t s_nxt;
	logic         fifo_rdy;

	// position in the line to pixel kind
	function automatic lct_pkg::lct_kind_t kind_of(input logic [lct_pkg::IDX_W-1:0] i);
		int n;
		n = int'(i);
		if (n < DARK - lct_pkg::LEAKY_PIX)
			return lct_pkg::PIX_DARK;
		if (n < DARK)
			return lct_pkg::PIX_LEAKY;
		if (n < DARK + lct_pkg::TRANS_PIX)
			return lct_pkg::PIX_TRANS;
		if (n < DARK + lct_pkg::TRANS_PIX + ACTIVE)
			return lct_pkg::PIX_ACTIVE;
		if (n < DARK + 2 * lct_pkg::TRANS_PIX)
			return lct_pkg::PIX_TRANS;
		if (n < DARK + 2 * lct_pkg::TRANS_PIX + ACTIVE)
			return lct_pkg::PIX_TRANS;
		if (n < DARK + 2 * lct_pkg::TRANS_PIX + ACTIVE + lct_pkg::LEAKY_PIX)
			return lct_pkg::PIX_LEAKY;
		return lct_pkg::PIX_DARK;
	endfunction

	// sequencer: transfer, drain pulse, then pixel shifting
	always_comb begin
		s_nxt       = s_r;
		s_nxt.sync1 = video_in;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.push  = s_r.push && !fifo_rdy; // a word the full buffer refused stays offered
		s_nxt.cnt   = s_r.cnt + 8'h01;
		if (s_r.ab_cnt != 8'h00)
			s_nxt.ab_cnt = s_r.ab_cnt - 8'h01;
		unique case (s_r.st)
			ST_IDLE: begin
				s_nxt.cnt = 8'h00;
				if (run)
					s_nxt.st = ST_TGDLY;
			end
			ST_TGDLY: begin
				if (s_r.cnt == 8'(lct_pkg::TG_RISE_CYC - 1)) begin
					s_nxt.st = ST_TGHI;
					s_nxt.cnt = 8'h00;
				end
			end
			ST_TGHI: begin
				if (s_r.cnt == 8'(lct_pkg::TG_PG_CYC - 1)) begin
					s_nxt.st = ST_PGHI;
					s_nxt.cnt = 8'h00;
				end
			end
			ST_PGHI: begin
				if (s_r.cnt == 8'(lct_pkg::PG_CYC - 1)) begin
					s_nxt.st = ST_TGEND;
					s_nxt.cnt = 8'h00;
				end
			end
			ST_TGEND: begin
				if (s_r.cnt == 8'(lct_pkg::PG_AB_CYC - 1))
					s_nxt.ab_cnt = 8'(lct_pkg::AB_CYC);
				if (s_r.cnt == 8'(lct_pkg::PG_TG_CYC - 1)) begin
					s_nxt.st = ST_PIXA;
					s_nxt.cnt = 8'h00;
					s_nxt.pix = '0;
				end
			end
			ST_PIXA: begin
				if (s_r.cnt == 8'h00 && !fifo_rdy)
					s_nxt.cnt = 8'h00; // stall with phase one high
				else if (s_r.cnt == 8'(lct_pkg::HALF_CYC - 1)) begin
					s_nxt.st = ST_PIXB;
					s_nxt.cnt = 8'h00;
				end
			end
			ST_PIXB: begin
				if (s_r.cnt == 8'(lct_pkg::HALF_CYC - 1)) begin
					s_nxt.cnt        = 8'h00;
					s_nxt.push       = 1'b1;
					s_nxt.word.video = s_r.sync2;
					s_nxt.word.idx   = s_r.pix;
					s_nxt.word.kind  = kind_of(s_r.pix);
					s_nxt.pix        = s_r.pix + 1'b1;
					if (s_r.pix == lct_pkg::IDX_W'(LINE - 1))
						s_nxt.st = ST_IDLE;
					else
						s_nxt.st = ST_PIXA;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// pin levels follow the next state
		s_nxt.p.tg = (s_nxt.st == ST_TGHI) || (s_nxt.st == ST_PGHI) || (s_nxt.st == ST_TGEND);
		s_nxt.p.pg = (s_nxt.st == ST_PGHI);
		s_nxt.p.ab = (s_nxt.ab_cnt != 8'h00);
		s_nxt.p.h1 = (s_nxt.st != ST_PIXB);
		s_nxt.p.h2 = (s_nxt.st == ST_PIXB);
		s_nxt.p.rg = (s_nxt.st == ST_PIXA) && (s_nxt.cnt < 8'(lct_pkg::RG_CYC));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_r <= RST_ST;
		else
			s_r <= s_nxt;
	end

	lct_fifo #(
		.WIDTH ($bits(lct_pkg::lct_pix_t)),
		.DEPTH (lct_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (s_r.push),
		.in_ready  (fifo_rdy),
		.in_data   (s_r.word),
		.out_valid (pix_valid),
		.out_ready (pix_ready),
		.out_data  (pix_data)
	);

	// pins straight from the state register
	assign transfer_gate_phase     = s_r.p.tg;
	assign photo_gate_phase        = s_r.p.pg;
	assign antiblooming_gate_phase = s_r.p.ab;
	assign shift_phase_one         = s_r.p.h1;
	assign shift_phase_two         = s_r.p.h2;
	assign output_reset_gate_phase = s_r.p.rg;

	// checks on the pin sequence
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence tg_close_s;
		transfer_gate_phase [*5] ##1 !transfer_gate_phase;
	endsequence

	tg_shift_low_a: assert property ((shift_phase_two || !shift_phase_one) |-> !transfer_gate_phase)
		else $error("transfer gate high while shifting");
	h_stopped_a: assert property ($rose(transfer_gate_phase) |->
		shift_phase_one && !shift_phase_two && $past(shift_phase_one, 3) && !$past(shift_phase_two, 3))
		else $error("shift clocks not stopped before transfer");
	tg_rise_dly_a: assert property ($rose(transfer_gate_phase) |-> $past(s_r.st, 4) == ST_IDLE)
		else $error("transfer gate rose too soon");
	pg_rise_a: assert property ($rose(photo_gate_phase) |->
		$past(transfer_gate_phase, 13) && !$past(transfer_gate_phase, 14))
		else $error("photo gate rise not 13 cycles after transfer gate");
	pg_width_a: assert property ($fell(photo_gate_phase) |->
		$past(photo_gate_phase, 100) && !$past(photo_gate_phase, 101))
		else $error("photo gate width not 100 cycles");
	tg_fall_a: assert property ($fell(photo_gate_phase) |-> tg_close_s)
		else $error("transfer gate fall not 5 cycles after photo gate");
	ab_width_a: assert property ($fell(antiblooming_gate_phase) |->
		$past(antiblooming_gate_phase, 187) && !$past(antiblooming_gate_phase, 188))
		else $error("drain pulse width not 187 cycles");
	h_comp_a: assert property (shift_phase_one != shift_phase_two || transfer_gate_phase == 1'b0 && shift_phase_one)
		else $error("shift phases not complementary");
	h_half_a: assert property ($rose(shift_phase_two) |-> shift_phase_two [*4] ##1 !shift_phase_two)
		else $error("phase two half period wrong");
	rg_low_a: assert property ($fell(shift_phase_one) |->
		!$past(output_reset_gate_phase, 1) && !$past(output_reset_gate_phase, 2))
		else $error("reset gate high before phase one fall");
	leaky_tag_a: assert property (s_r.push && s_r.word.kind == lct_pkg::PIX_DARK |->
		int'(s_r.word.idx) < DARK - 2 || int'(s_r.word.idx) >= LINE - TAIL + 2)
		else $error("leaky dark pixel tagged as reference");
	line_len_a: assert property ($rose(transfer_gate_phase) && s_r.pix != '0 |->
		int'(s_r.pix) == LINE)
		else $error("line length wrong");
endmodule
`default_nettype wire

/* lct_img.sv */
// behavioural imager: pixel register, dark layout, pin order checks
`default_nettype none
module lct_img #(
	parameter int LINE_LEN = 524,
	parameter int DARK     = 8
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      transfer_gate_phase,
	input  wire logic                      photo_gate_phase,
	input  wire logic                      shift_phase_one,
	input  wire logic                      shift_phase_two,
	input  wire logic                      output_reset_gate_phase,
	output var  logic [lct_pkg::VID_W-1:0] video_in,
	output var  int                        viol
);
	timeunit 1ns;
	timeprecision 1ps;
	int          line_no = 0;
	int          pos = 0;
	bit          loaded = 1'b0;
	logic [11:0] held = 12'h000;
	realtime     last_fall = 0;
	initial viol = 0;
	// packet content: leaky dark pixels pick up stray light
	function automatic logic [11:0] pix(int l, int i);
		return 12'((l << 8) + 3 * i + ((i >= DARK - 2 && i < DARK) ? 12'h040 : 12'h000));
	endfunction
	// photodiodes load the register when the transfer gate closes
	always @(negedge transfer_gate_phase) if (!rst) begin
		if (loaded && pos < LINE_LEN) viol++;
		if (photo_gate_phase !== 1'b0) viol++;
		loaded = 1'b1;
		pos = 0;
		line_no++;
	end
	// transfer order
	always @(posedge transfer_gate_phase) if (!rst && {shift_phase_one, shift_phase_two} !== 2'h2) viol++;
	always @(posedge photo_gate_phase) if (!rst && transfer_gate_phase !== 1'b1) viol++;
	// each fall of phase one dumps the next packet on the output node
	always @(negedge shift_phase_one) if (!rst) begin
		if (output_reset_gate_phase !== 1'b0 || transfer_gate_phase !== 1'b0) viol++;
		if ($realtime - last_fall < 25.0) viol++;
		last_fall = $realtime;
		held = (loaded && pos < LINE_LEN) ? pix(line_no, pos) : ~held;
		pos++;
	end
	// phases stay complementary between edges
	always @(negedge clk) if (!rst && shift_phase_one === shift_phase_two) viol++;
	// reset level differs from the last packet
	assign video_in = output_reset_gate_phase ? ~held : held;
endmodule
`default_nettype wire

/* lct_ctrl_tb.sv */
// self-checking bench: controller, imager model, pixel scoreboard
`default_nettype none
module lct_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ACT  = 512;
	localparam int DRK  = 8;
	localparam int LLEN = DRK + 4 + ACT;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b0;
	logic pix_ready = 1'b1;
	logic rnd_on = 1'b0;
	logic transfer_gate_phase, photo_gate_phase, antiblooming_gate_phase;
	logic shift_phase_one, shift_phase_two, output_reset_gate_phase, pix_valid;
	logic [lct_pkg::VID_W-1:0] video_in;
	lct_pkg::lct_pix_t         pix_data;
	wire logic [1:0]           mon = {transfer_gate_phase, shift_phase_one};
	int err_total = 0, num_checks = 0, viol, cyc = 0, got = 0, n_tg = 0, hold;
	int t_run, t_tg, t_tgf, t_pg, t_pgf, t_ab, t_abf, t_h1f, t_h1r = 0;
	lct_ctrl #(.ACTIVE(ACT), .DARK(DRK), .TAIL(0)) u_dut (.clk, .rst, .run, .video_in, .transfer_gate_phase,
		.photo_gate_phase, .antiblooming_gate_phase, .shift_phase_one, .shift_phase_two,
		.output_reset_gate_phase, .pix_valid, .pix_ready, .pix_data);
	lct_img #(.LINE_LEN(LLEN), .DARK(DRK)) u_img (.clk, .rst, .transfer_gate_phase, .photo_gate_phase,
		.shift_phase_one, .shift_phase_two, .output_reset_gate_phase, .video_in, .viol);
	initial forever #2 clk = ~clk;
	task automatic final_report();
		if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic bail();
		err_total++;
		$display("MISMATCH %0t wait ran out", $time);
		final_report();
	endtask
	task automatic wait_lvl(input int b, input logic v, input int lim);
		int k;
		k = 0;
		while (mon[b] !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
		if (mon[b] !== v) bail();
	endtask
	task automatic wait_got(input int n);
		int k;
		k = 0;
		while (got < n && k < 30000) begin
			@(negedge clk);
			k++;
		end
		if (got < n) bail();
	endtask
	// expected word from the count of taken words
	function automatic logic [25:0] exp_word(int n);
		int i, l;
		logic [1:0] k;
		i = n % LLEN;
		l = n / LLEN + 1;
		k = (i < DRK - 2) ? 2'h0 : (i < DRK) ? 2'h1 : (i < DRK + 2 || i >= DRK + 2 + ACT) ? 2'h2 : 2'h3;
		return {k, 12'(i), 12'((l << 8) + 3 * i + ((i >= DRK - 2 && i < DRK) ? 12'h040 : 12'h000))};
	endfunction
	// cycle count and scoreboard
	always @(posedge clk) begin
		cyc++;
		if (!rst && pix_valid && pix_ready) begin
			check(pix_data, exp_word(got));
			got++;
		end
	end
	// edge stamps of the gate pins and of shift phase one
	always @(posedge transfer_gate_phase) begin
		t_tg = cyc;
		n_tg++;
		if (t_h1r > 0) check(cyc - t_h1r >= 3, 1);
	end
	always @(negedge transfer_gate_phase) t_tgf = cyc;
	always @(posedge photo_gate_phase) t_pg = cyc;
	always @(negedge photo_gate_phase) t_pgf = cyc;
	always @(posedge antiblooming_gate_phase) t_ab = cyc;
	always @(negedge antiblooming_gate_phase) t_abf = cyc;
	always @(negedge shift_phase_one) t_h1f = cyc;
	always @(posedge shift_phase_one) t_h1r = cyc;
	// random consumer stalls
	always @(negedge clk) if (rnd_on) pix_ready = ($urandom_range(3, 0) != 0);
	initial begin
		void'($urandom(37975));
		repeat (5) @(posedge clk);
		@(negedge clk);
		check({mon, shift_phase_two, photo_gate_phase, antiblooming_gate_phase, pix_valid}, 6'h10);
		rst = 1'b0;
		run = 1'b1;
		t_run = cyc + 1;
		wait_lvl(1, 1'b1, 10);
		wait_lvl(1, 1'b0, 200);
		wait_lvl(0, 1'b0, 10);
		check(t_tg - t_run, 3);
		check(t_pg - t_tg, 13);
		check(t_pgf - t_pg, 100);
		check(t_tgf - t_pgf, 5);
		check(t_ab - t_pgf, 2);
		check(t_h1f - t_tgf, 4);
		// full buffer stretches phase one
		pix_ready = 1'b0;
		repeat (300) @(negedge clk);
		check(t_abf - t_ab, 187);
		check({mon, output_reset_gate_phase, pix_valid, antiblooming_gate_phase}, 5'h0E);
		hold = t_h1f;
		repeat (40) @(negedge clk);
		check(t_h1f, hold);
		rnd_on = 1'b1;
		wait_got(LLEN + 20);
		run = 1'b0;
		wait_got(2 * LLEN);
		rnd_on = 1'b0;
		@(negedge clk);
		pix_ready = 1'b1;
		repeat (200) @(negedge clk);
		check(n_tg, 2);
		check({pix_valid, mon, shift_phase_two}, 4'h2);
		check(viol, 0);
		check(got, 2 * LLEN);
		final_report();
	end
endmodule
`default_nettype wire
